// ===== design/iow_ctrl.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
// Contract
// - Config register write-only at C8h, reset 00h, whole-byte writes only.
// - Bit 6 set makes source 1 level sensitive, clear edge sensitive.
// - Bit 5 selects the edge polarity of source 2.
// - Bit 4 global enable; clear disables all sources except non-maskable.
// - With enable low, non-maskable is serviced but does not wake.
// - Timer overflow and converter end-of-conversion, each gated, go to vector 4.
// - Reload timer overflow, compare, input edge, each gated, go to vector 3.
// - Port A/B interrupt pins raise vector 1, port C pins vector 2.
// - WAIT stops fetch, oscillator and peripherals keep running.
// - Interrupt ending WAIT resumes with no stabilisation delay.
// - STOP only with watchdog off; oscillator halts until external irq or reset.
// - Interrupt ending STOP waits a stabilisation delay before first instruction.
// - Reset during WAIT or STOP gives the normal reset procedure.
// - Wake-up leaves the oscillator source selection unchanged.
// - From main program, any interrupt wakes, services, then continues.
// - From non-maskable routine, wake continues in non-maskable mode, nothing taken.
// - From maskable routine, maskable wake continues routine; pending served later.
// - From maskable routine, non-maskable wake runs first, then routine resumes.
// - With watchdog active, STOP executes as WAIT.
// - WAIT and STOP are skipped when an enabled request is pending.
// - With global enable cleared, WAIT or STOP is left only by reset.
// - Source 2 triggers on rising edge when polarity set, falling when clear.
// - Edge latch sets on edge, clears at service start, keeps only one.
// - Sources 3 and 4 level sensitive, no storage, sampled per instruction.
// - Non-maskable request latched, cleared when its routine begins.
module iow_ctrl #(
	parameter int STAB_CYCLES = iow_pkg::STAB_CYCLES,
	parameter int PA_W = 8,
	parameter int PB_W = 8,
	parameter int PC_W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// External pins, asynchronous
	input wire logic nmi_pin_n,
	input wire logic [PA_W-1:0] port_a_pin,
	input wire logic [PB_W-1:0] port_b_pin,
	input wire logic [PC_W-1:0] port_c_pin,
	// Port interrupt selection, from port option and data registers
	input wire logic [PA_W-1:0] port_a_irq_sel,
	input wire logic [PB_W-1:0] port_b_irq_sel,
	input wire logic [PC_W-1:0] port_c_irq_sel,
	// Peripheral events and enables
	input wire logic timer_overflow_flag,
	input wire logic timer_irq_enable,
	input wire logic converter_eoc_flag,
	input wire logic converter_irq_enable,
	input wire logic reload_overflow_flag,
	input wire logic reload_overflow_irq_enable,
	input wire logic compare_match_flag,
	input wire logic compare_irq_enable,
	input wire logic input_edge_flag,
	input wire logic input_edge_irq_enable,
	// Core interface
	input wire logic instr_end,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic irq_ack,
	input wire logic reti,
	input wire logic watchdog_active,
	input wire logic [1:0] osc_select_in,
	output logic [2:0] irq_vector,
	output logic irq_take,
	output logic core_run,
	output logic osc_enable,
	output logic periph_clk_enable,
	output logic [1:0] osc_select,
	output logic [1:0] core_ctx,
	output logic [1:0] power_state
);
	// ==========================================
	// State
	typedef struct packed {
		logic [7:0] cfg;
		logic src1_prev;
		logic src2_prev;
		logic src1_latch;
		logic src2_latch;
		logic nmi_prev;
		logic nmi_latch;
		logic [3:0] level_samp;
		iow_pkg::iow_ctx_t ctx;
		iow_pkg::iow_ctx_t ctx_saved;
		iow_pkg::iow_pwr_t pwr;
		logic [15:0] stab_cnt;
		logic [2:0] vec;
		logic take;
		logic [7:0] rdata;
	} iow_st_t;
	iow_st_t st_q, st_d;

	localparam int NPIN = PA_W + PB_W + PC_W + 1;
	logic [NPIN-1:0] pins_s;
	logic nmi_n_s;
	logic [PA_W-1:0] pa_s;
	logic [PB_W-1:0] pb_s;
	logic [PC_W-1:0] pc_s;

	iow_sync #(.W(NPIN)) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in({nmi_pin_n, port_a_pin, port_b_pin, port_c_pin}),
		.sync_out(pins_s)
	);
	assign {nmi_n_s, pa_s, pb_s, pc_s} = pins_s;

	// Active-low pin request: a selected pin is asserting when low.
	function automatic logic any_low(input logic [31:0] pins, input logic [31:0] sel);
		any_low = |(~pins & sel);
	endfunction

	// ==========================================
	// Request decode
	logic global_irq_enable, lvl1, pol2;
	logic src1_line, src2_line, src3_lvl, src4_lvl;
	logic src1_req, src2_req, any_mask_req, nmi_req, ext_req;
	logic rise2, fall2, edge1, edge2;

	always_comb begin
		global_irq_enable = st_q.cfg[iow_pkg::GLOBAL_EN_BIT];
		lvl1 = st_q.cfg[iow_pkg::LEVEL_BIT];
		pol2 = st_q.cfg[iow_pkg::POL_BIT];
		// Line is high while a request is asserted.
		src1_line = any_low(32'(pa_s), 32'(port_a_irq_sel))
			| any_low(32'(pb_s), 32'(port_b_irq_sel));
		src2_line = any_low(32'(pc_s), 32'(port_c_irq_sel));
		src3_lvl = (reload_overflow_flag & reload_overflow_irq_enable)
			| (compare_match_flag & compare_irq_enable)
			| (input_edge_flag & input_edge_irq_enable);
		src4_lvl = (timer_overflow_flag & timer_irq_enable)
			| (converter_eoc_flag & converter_irq_enable);
		edge1 = src1_line & ~st_q.src1_prev;
		rise2 = ~src2_line & st_q.src2_prev;
		fall2 = src2_line & ~st_q.src2_prev;
		edge2 = pol2 ? rise2 : fall2;
		src1_req = lvl1 ? src1_line : st_q.src1_latch;
		src2_req = st_q.src2_latch;
		any_mask_req = global_irq_enable & (src1_req | src2_req | st_q.level_samp[2]
			| st_q.level_samp[3]);
		nmi_req = st_q.nmi_latch;
		// Wake uses the live peripheral levels, since no instruction ends while the core sleeps.
		ext_req = global_irq_enable & (src1_req | src2_req | src3_lvl | src4_lvl
			| nmi_req);
	end

	// ==========================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.take = 1'b0;
		st_d.rdata = 8'h00;
		st_d.src1_prev = src1_line;
		st_d.src2_prev = src2_line;
		st_d.nmi_prev = ~nmi_n_s;
		// Whole-byte write only; reads return nothing since the register is write-only.
		if (reg_write && reg_addr == iow_pkg::CFG_ADDR) begin
			st_d.cfg = reg_wdata & iow_pkg::CFG_USED_MASK;
		end
		// Edge latches: set wins over clear, a second edge is absorbed.
		if (irq_ack && st_q.vec == iow_pkg::VEC_1) begin
			st_d.src1_latch = 1'b0;
		end
		if (irq_ack && st_q.vec == iow_pkg::VEC_2) begin
			st_d.src2_latch = 1'b0;
		end
		if (irq_ack && st_q.vec == iow_pkg::VEC_NMI) begin
			st_d.nmi_latch = 1'b0;
		end
		if (edge1 && !lvl1) begin
			st_d.src1_latch = 1'b1;
		end
		if (edge2) begin
			st_d.src2_latch = 1'b1;
		end
		if (~nmi_n_s && !st_q.nmi_prev) begin
			st_d.nmi_latch = 1'b1;
		end
		if (instr_end) begin
			st_d.level_samp = {src4_lvl, src3_lvl, 2'b00};
		end
		// Vector offer: NMI except inside its own routine, maskable only outside any routine.
		st_d.vec = iow_pkg::VEC_NONE;
		if (nmi_req && st_q.ctx != iow_pkg::CTX_NMI) begin
			st_d.vec = iow_pkg::VEC_NMI;
		end else if (global_irq_enable && st_q.ctx == iow_pkg::CTX_NORMAL) begin
			if (src1_req) st_d.vec = iow_pkg::VEC_1;
			else if (src2_req) st_d.vec = iow_pkg::VEC_2;
			else if (st_q.level_samp[2]) st_d.vec = iow_pkg::VEC_3;
			else if (st_q.level_samp[3]) st_d.vec = iow_pkg::VEC_4;
		end
		// Context tracking across service entry and return.
		if (irq_ack && st_q.vec == iow_pkg::VEC_NMI) begin
			st_d.ctx_saved = st_q.ctx;
			st_d.ctx = iow_pkg::CTX_NMI;
		end else if (irq_ack && st_q.vec != iow_pkg::VEC_NONE) begin
			st_d.ctx = iow_pkg::CTX_IRQ;
		end else if (reti) begin
			st_d.ctx = (st_q.ctx == iow_pkg::CTX_NMI) ? st_q.ctx_saved
				: iow_pkg::CTX_NORMAL;
		end
		// Power sequencing.
		case (st_q.pwr)
			iow_pkg::PWR_RUN: begin
				if ((wait_exec || stop_exec) && st_q.vec == iow_pkg::VEC_NONE
					&& !any_mask_req) begin
					if (stop_exec && !watchdog_active) begin
						st_d.pwr = iow_pkg::PWR_STOP;
					end else begin
						st_d.pwr = iow_pkg::PWR_WAIT;
					end
				end
			end
			iow_pkg::PWR_WAIT: begin
				if (ext_req) begin
					st_d.pwr = iow_pkg::PWR_RUN;
					st_d.take = (st_q.ctx != iow_pkg::CTX_NMI);
				end
			end
			iow_pkg::PWR_STOP: begin
				if (ext_req) begin
					st_d.pwr = iow_pkg::PWR_STAB;
					st_d.stab_cnt = 16'(STAB_CYCLES - 1);
				end
			end
			iow_pkg::PWR_STAB: begin
				if (st_q.stab_cnt == 16'h0000) begin
					st_d.pwr = iow_pkg::PWR_RUN;
					st_d.take = (st_q.ctx != iow_pkg::CTX_NMI);
				end else begin
					st_d.stab_cnt = st_q.stab_cnt - 16'h0001;
				end
			end
			default: begin
				st_d.pwr = iow_pkg::PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_q.cfg <= iow_pkg::CFG_RESET;
			st_q.src1_prev <= 1'b0;
			st_q.src2_prev <= 1'b0;
			st_q.src1_latch <= 1'b0;
			st_q.src2_latch <= 1'b0;
			st_q.nmi_prev <= 1'b0;
			st_q.nmi_latch <= 1'b0;
			st_q.level_samp <= 4'h0;
			st_q.ctx <= iow_pkg::CTX_NORMAL;
			st_q.ctx_saved <= iow_pkg::CTX_NORMAL;
			st_q.pwr <= iow_pkg::PWR_RUN;
			st_q.stab_cnt <= 16'h0000;
			st_q.vec <= iow_pkg::VEC_NONE;
			st_q.take <= 1'b0;
			st_q.rdata <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = st_q.rdata;
	assign irq_vector = st_q.vec;
	assign irq_take = st_q.take;
	assign core_run = (st_q.pwr == iow_pkg::PWR_RUN);
	assign osc_enable = (st_q.pwr != iow_pkg::PWR_STOP);
	assign periph_clk_enable = (st_q.pwr == iow_pkg::PWR_RUN)
		|| (st_q.pwr == iow_pkg::PWR_WAIT);
	assign osc_select = osc_select_in;
	assign core_ctx = st_q.ctx;
	assign power_state = st_q.pwr;

	// ==========================================
	// Checks
	property p_stop_wait_len;
		@(posedge clock) disable iff (!reset_n)
		(st_q.pwr == iow_pkg::PWR_STOP && ext_req)
			|=> (st_q.pwr == iow_pkg::PWR_STAB && st_q.stab_cnt == 16'(STAB_CYCLES - 1));
	endproperty
	a_stop_wait_len: assert property (p_stop_wait_len) else $error("stop woke early");

	property p_stab_hold;
		@(posedge clock) disable iff (!reset_n)
		(st_q.pwr == iow_pkg::PWR_STAB && st_q.stab_cnt != 16'h0000)
			|=> (st_q.pwr == iow_pkg::PWR_STAB && !core_run);
	endproperty
	a_stab_hold: assert property (p_stab_hold) else $error("stabilisation cut short");

	property p_rdata_zero;
		@(posedge clock) disable iff (!reset_n)
		$past(reg_read) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("config read back");

	property p_wait_fast;
		@(posedge clock) disable iff (!reset_n)
		(st_q.pwr == iow_pkg::PWR_WAIT && ext_req) |=> core_run;
	endproperty
	a_wait_fast: assert property (p_wait_fast) else $error("wait wake delayed");

	property p_no_wake_disabled;
		@(posedge clock) disable iff (!reset_n)
		(st_q.pwr == iow_pkg::PWR_WAIT && !global_irq_enable) |=> !core_run;
	endproperty
	a_no_wake_disabled: assert property (p_no_wake_disabled) else $error("woke with enable low");

	property p_stop_wdg;
		@(posedge clock) disable iff (!reset_n)
		(core_run && stop_exec && watchdog_active) |=> st_q.pwr != iow_pkg::PWR_STOP;
	endproperty
	a_stop_wdg: assert property (p_stop_wdg) else $error("stop with watchdog");

	property p_skip_pending;
		@(posedge clock) disable iff (!reset_n)
		(core_run && wait_exec && any_mask_req) |=> core_run;
	endproperty
	a_skip_pending: assert property (p_skip_pending) else $error("wait with pending");

	property p_osc_stop;
		@(posedge clock) disable iff (!reset_n)
		(st_q.pwr == iow_pkg::PWR_STOP) |-> !osc_enable && !periph_clk_enable;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator on in stop");

	property p_mask_disabled;
		@(posedge clock) disable iff (!reset_n)
		!$past(global_irq_enable)
			|-> (irq_vector == iow_pkg::VEC_NONE || irq_vector == iow_pkg::VEC_NMI);
	endproperty
	a_mask_disabled: assert property (p_mask_disabled) else $error("maskable while disabled");

	property p_nmi_latch;
		@(posedge clock) disable iff (!reset_n)
		($fell(nmi_n_s) && !(irq_ack && st_q.vec == iow_pkg::VEC_NMI)) |=> st_q.nmi_latch;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) else $error("nmi not latched");

	property p_nmi_ctx_stay;
		@(posedge clock) disable iff (!reset_n)
		(st_q.ctx == iow_pkg::CTX_NMI && !reti) |=> st_q.ctx == iow_pkg::CTX_NMI;
	endproperty
	a_nmi_ctx_stay: assert property (p_nmi_ctx_stay) else $error("left nmi mode");
endmodule

// ===== design/iow_pkg.sv
package iow_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] CFG_ADDR = 8'hc8;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int LEVEL_BIT = 6;
	localparam int POL_BIT = 5;
	localparam int GLOBAL_EN_BIT = 4;
	localparam logic [7:0] CFG_USED_MASK = 8'h70;
	// ==========================================
	// Timing
	localparam int CLOCK_HZ = 20000000;
	localparam int STAB_CYCLES = 16;
	// ==========================================
	// Vector codes offered to the core
	localparam logic [2:0] VEC_NONE = 3'h7;
	localparam logic [2:0] VEC_NMI = 3'h0;
	localparam logic [2:0] VEC_1 = 3'h1;
	localparam logic [2:0] VEC_2 = 3'h2;
	localparam logic [2:0] VEC_3 = 3'h3;
	localparam logic [2:0] VEC_4 = 3'h4;
	// ==========================================
	// Core context and power states
	typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} iow_ctx_t;
	typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP, PWR_STAB} iow_pwr_t;
endpackage

// ===== design/iow_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a bus of pin levels.
module iow_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} iow_sync_st_t;
	iow_sync_st_t st_q, st_d;

	always_comb begin
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			// Reset to the idle high level of the active-low pins, so no false edge follows.
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule

// ===== bench/iow_core_model.sv
`timescale 1ns/100ps
// Behavioural core: ends an instruction every fourth cycle while it runs, takes an
// offered vector when the bench allows it, and returns eight cycles after the take.
module iow_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Design side
	input wire logic core_run,
	input wire logic [2:0] irq_vector,
	// Bench control
	input wire logic ack_en,
	// Core strobes
	output logic instr_end,
	output logic irq_ack,
	output logic reti
);
	logic [1:0] phase_q;
	logic [3:0] ret_q;
	always @(posedge clock) begin
		instr_end <= 1'b0;
		irq_ack <= 1'b0;
		reti <= 1'b0;
		if (!reset_n) begin
			phase_q <= 2'h0;
			ret_q <= 4'h0;
		end else if (core_run) begin
			phase_q <= phase_q + 2'h1;
			instr_end <= (phase_q == 2'h3);
			if (ack_en && irq_vector !== iow_pkg::VEC_NONE && !irq_ack && ret_q == 4'h0) begin
				irq_ack <= 1'b1;
				ret_q <= 4'h8;
			end else if (ret_q != 4'h0) begin
				ret_q <= ret_q - 4'h1;
				reti <= (ret_q == 4'h1);
			end
		end
	end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam int STAB = 4;
	logic clock, reset_n, reg_write, reg_read, nmi_pin_n, instr_end, irq_ack, reti, ack_en;
	logic wait_exec, stop_exec, watchdog_active, irq_take, core_run, osc_enable, periph_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pa, pb, pc, sa, sb, sc;
	logic [9:0] pf;
	logic [1:0] osc_in, osc_select, core_ctx, power_state;
	logic [2:0] irq_vector;
	logic [15:0] rnd;
	int errors = 0, samples_checked = 0, takes = 0, t0, st;
	// ==========================================
	// Design and core model
	iow_ctrl #(.STAB_CYCLES(STAB)) uut (.clock(clock), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .nmi_pin_n(nmi_pin_n),
		.port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc), .port_a_irq_sel(sa),
		.port_b_irq_sel(sb), .port_c_irq_sel(sc), .timer_overflow_flag(pf[0]),
		.timer_irq_enable(pf[1]), .converter_eoc_flag(pf[2]), .converter_irq_enable(pf[3]),
		.reload_overflow_flag(pf[4]), .reload_overflow_irq_enable(pf[5]),
		.compare_match_flag(pf[6]), .compare_irq_enable(pf[7]), .input_edge_flag(pf[8]),
		.input_edge_irq_enable(pf[9]), .instr_end(instr_end), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .irq_ack(irq_ack), .reti(reti),
		.watchdog_active(watchdog_active), .osc_select_in(osc_in), .irq_vector(irq_vector),
		.irq_take(irq_take), .core_run(core_run), .osc_enable(osc_enable),
		.periph_clk_enable(periph_en), .osc_select(osc_select), .core_ctx(core_ctx),
		.power_state(power_state));
	iow_core_model core (.clock(clock), .reset_n(reset_n), .core_run(core_run),
		.irq_vector(irq_vector), .ack_en(ack_en), .instr_end(instr_end), .irq_ack(irq_ack),
		.reti(reti));
	// ==========================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [2:0] exp_vec(input logic [9:0] f, input logic enable);
		if (!enable) return iow_pkg::VEC_NONE;
		if ((f[4] & f[5]) | (f[6] & f[7]) | (f[8] & f[9])) return iow_pkg::VEC_3;
		if ((f[0] & f[1]) | (f[2] & f[3])) return iow_pkg::VEC_4;
		return iow_pkg::VEC_NONE;
	endfunction
	function automatic logic [2:0] obs(input int w);
		return w == 0 ? {1'b0, power_state} : w == 1 ? irq_vector : {1'b0, core_ctx};
	endfunction
	task automatic finish_test;
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_on(input string name, input int w, input logic [2:0] v, input int n);
		for (int i = 0; i < n && obs(w) !== v; i++) tick(1);
		chk(name, {5'h0, v}, {5'h0, obs(w)});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock) reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock) reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock) reg_read <= 1'b0;
		#1 chk("reg_rdata", 8'h00, reg_rdata);
	endtask
	task automatic pulse(input logic stop);
		@(posedge clock) wait_exec <= !stop;
		stop_exec <= stop;
		@(posedge clock) wait_exec <= 1'b0;
		stop_exec <= 1'b0;
	endtask
	task automatic ack_cycle;
		@(posedge clock) ack_en <= 1'b1;
		wait_on("core_ctx", 2, 3'h1, 20);
		@(posedge clock) ack_en <= 1'b0;
		wait_on("core_ctx", 2, 3'h0, 20);
		chk("irq_vector", {5'h0, iow_pkg::VEC_NONE}, {5'h0, irq_vector});
	endtask
	// ==========================================
	// Clock, takes and watchdog
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) if (irq_take === 1'b1) takes <= takes + 1;
	initial begin
		#(50 * 6000);
		errors++;
		finish_test();
	end
	// ==========================================
	// Tests
	initial begin
		{reset_n, reg_write, reg_read, wait_exec, stop_exec, watchdog_active, ack_en} = '0;
		{reg_addr, reg_wdata, sa, sb, sc, pf, osc_in} = '0;
		{pa, pb, pc} = '1;
		nmi_pin_n = 1'b1;
		rnd = 16'd9160;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		tick(3);
		chk("irq_vector", {5'h0, iow_pkg::VEC_NONE}, {5'h0, irq_vector});
		rd(iow_pkg::CFG_ADDR);
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			@(posedge clock) pf <= rnd[9:0];
			osc_in <= rnd[11:10];
			{sa, sb, sc} <= {3{rnd[15:8]}};
			wr(iow_pkg::CFG_ADDR, {rnd[15], 2'b00, rnd[12], rnd[3:0]});
			tick(14);
			chk("irq_vector", {5'h0, exp_vec(pf, rnd[12])}, {5'h0, irq_vector});
			chk("osc_select", {6'h0, osc_in}, {6'h0, osc_select});
			rd(rnd[7:0]);
		end
		@(posedge clock) pf <= '0;
		{sa, sc} <= 16'h0101;
		wr(iow_pkg::CFG_ADDR, 8'h10);
		@(posedge clock) pa <= 8'hfe;
		tick(2);
		@(posedge clock) pa <= 8'hff;
		wait_on("irq_vector", 1, iow_pkg::VEC_1, 12);
		ack_cycle();
		wr(iow_pkg::CFG_ADDR, 8'h50);
		@(posedge clock) pa <= 8'hfe;
		wait_on("irq_vector", 1, iow_pkg::VEC_1, 12);
		@(posedge clock) pa <= 8'hff;
		wait_on("irq_vector", 1, iow_pkg::VEC_NONE, 12);
		wr(iow_pkg::CFG_ADDR, 8'h10);
		@(posedge clock) pc <= 8'hfe;
		wait_on("irq_vector", 1, iow_pkg::VEC_2, 12);
		ack_cycle();
		wr(iow_pkg::CFG_ADDR, 8'h30);
		tick(12);
		chk("irq_vector", {5'h0, iow_pkg::VEC_NONE}, {5'h0, irq_vector});
		@(posedge clock) pc <= 8'hff;
		wait_on("irq_vector", 1, iow_pkg::VEC_2, 12);
		ack_cycle();
		wr(iow_pkg::CFG_ADDR, 8'h10);
		pulse(1'b0);
		wait_on("power_state", 0, 3'h1, 4);
		chk("run_osc_periph", 8'h03, {5'h0, core_run, osc_enable, periph_en});
		t0 = takes;
		@(posedge clock) pf <= 10'h003;
		wait_on("power_state", 0, 3'h0, 3);
		tick(2);
		chk("irq_take", 8'h01, 8'(takes - t0));
		tick(12);
		pulse(1'b0);
		tick(4);
		chk("power_state", 8'h00, {6'h0, power_state});
		@(posedge clock) pf <= '0;
		tick(12);
		pulse(1'b1);
		wait_on("power_state", 0, 3'h2, 4);
		chk("osc_enable", 8'h00, {7'h0, osc_enable});
		@(posedge clock) pf <= 10'h030;
		st = 0;
		for (int i = 0; i < 40 && power_state !== 2'h0; i++) begin
			tick(1);
			if (power_state === 2'h3) st++;
		end
		chk("stab_cycles", STAB[7:0], 8'(st));
		chk("osc_select", {6'h0, osc_in}, {6'h0, osc_select});
		@(posedge clock) pf <= '0;
		watchdog_active <= 1'b1;
		tick(12);
		pulse(1'b1);
		wait_on("power_state", 0, 3'h1, 4);
		@(posedge clock) pf <= 10'h00c;
		wait_on("power_state", 0, 3'h0, 3);
		@(posedge clock) pf <= '0;
		watchdog_active <= 1'b0;
		nmi_pin_n <= 1'b0;
		wait_on("irq_vector", 1, iow_pkg::VEC_NMI, 12);
		@(posedge clock) ack_en <= 1'b1;
		wait_on("core_ctx", 2, 3'h2, 20);
		@(posedge clock) ack_en <= 1'b0;
		nmi_pin_n <= 1'b1;
		wait_on("core_ctx", 2, 3'h0, 20);
		chk("irq_vector", {5'h0, iow_pkg::VEC_NONE}, {5'h0, irq_vector});
		wr(iow_pkg::CFG_ADDR, 8'h00);
		tick(12);
		pulse(1'b0);
		wait_on("power_state", 0, 3'h1, 4);
		@(posedge clock) pf <= 10'h003;
		nmi_pin_n <= 1'b0;
		tick(20);
		chk("power_state", 8'h01, {6'h0, power_state});
		@(posedge clock) reset_n <= 1'b0;
		tick(3);
		@(posedge clock) reset_n <= 1'b1;
		tick(1);
		chk("power_ctx_vec", 8'h07, {1'b0, power_state, core_ctx, irq_vector});
		finish_test();
	end
endmodule
